// ==== core/ptc_pkg.sv ====
// trace program control: register map, field layout, reset values, event codes
// assumes a 32-bit debug apb with byte addresses and word-aligned registers
package ptc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_MAIN_CTL = 12'h000;
    localparam logic [11:0] OFS_TRIG_EVT = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_TE_STARTSTOP = 12'h018;
    localparam logic [11:0] OFS_TE_EVT = 12'h020;
    localparam logic [11:0] OFS_TE_CTL1 = 12'h024;
    localparam logic [11:0] OFS_EXTOUT_EVT1 = 12'h1A0;
    localparam logic [11:0] OFS_EXTOUT_EVT2 = 12'h1A4;
    localparam logic [11:0] OFS_SYNC_FREQ = 12'h1E0;
    localparam logic [11:0] OFS_XIN_SEL = 12'h1EC;
    localparam logic [11:0] OFS_TRACE_ID = 12'h200;
    localparam logic [11:0] OFS_LOCK_ACCESS = 12'hFB0;
    localparam logic [11:0] OFS_LOCK_STATUS = 12'hFB4;
    localparam logic [11:0] OFS_ID_FIRST = 12'hFD0;

    // main control: writable bits and the configuration hold bit
    localparam logic [31:0] MAIN_CTL_WMASK = 32'h7000_D700;
    localparam logic [31:0] MAIN_CTL_RST = 32'h0000_0000;
    localparam int HOLD_BIT = 10;
    localparam int STAT_HOLD_BIT = 1;

    // reset values of initialised registers
    localparam logic [31:0] SYNC_FREQ_RST = 32'h0000_0400;
    localparam logic [6:0] TRACE_ID_RST = 7'h00;
    localparam logic [31:0] LOCK_KEY = 32'h1234_5678; // arbitrary value

    // extended input selector fields
    localparam int XIN_SEL_W = 7;
    localparam int XIN_SEL2_LSB = 8;
    localparam int PMU_EVT_W = 88;
    localparam int NUM_XSEL = 2;

    // event resource encoding: type in [6:4], index in [3:0]
    localparam int EVT_W = 7;
    localparam int NUM_EVT = 4;
    localparam logic [2:0] RT_SINGLE = 3'h0;
    localparam logic [2:0] RT_RANGE = 3'h1;
    localparam logic [2:0] RT_COUNTER = 3'h4;
    localparam logic [2:0] RT_STATE = 3'h5;
    localparam logic [2:0] RT_INPUT = 3'h6;
    localparam logic [3:0] IX_CTXID = 4'h8;
    localparam logic [3:0] IX_VMID = 4'hB;
    localparam logic [3:0] IX_STARTSTOP = 4'hF;
    localparam logic [3:0] IX_XSEL1 = 4'h8;
    localparam logic [3:0] IX_XSEL2 = 4'h9;
    localparam logic [3:0] IX_NONSEC = 4'hD;
    localparam logic [3:0] IX_PROHIB = 4'hE;
    localparam logic [3:0] IX_ALWAYS = 4'hF;

    // trace byte packing
    localparam int PACK_BYTES = 4;
    localparam logic [2:0] PACK_FULL = 3'h4;
endpackage : ptc_pkg

// ==== core/ptc_event_decode.sv ====
// trace program control: event resource decoder
// assumes all resource inputs are already synchronous to the block clock
`timescale 1ns/100ps
module ptc_event_decode (
    input wire logic [ptc_pkg::EVT_W-1:0] evt_sel,
    input wire logic [7:0] addr_single,
    input wire logic [3:0] addr_range,
    input wire logic [1:0] cnt_zero,
    input wire logic [2:0] seq_state,
    input wire logic ctxid_match,
    input wire logic vmid_match,
    input wire logic startstop,
    input wire logic [3:0] ext_in,
    input wire logic [1:0] xsel_evt,
    input wire logic nonsecure,
    input wire logic prohibited,
    output logic evt_true
);
    logic [2:0] rtype;
    logic [3:0] idx;

    assign rtype = evt_sel[6:4];
    assign idx = evt_sel[3:0];

    // unlisted type/index pairs resolve false
    always_comb begin
        evt_true = 1'b0;
        case (rtype)
            ptc_pkg::RT_SINGLE: if (idx < 4'h8) evt_true = addr_single[idx[2:0]];
            ptc_pkg::RT_RANGE: if (idx < 4'h4) evt_true = addr_range[idx[1:0]];
            ptc_pkg::RT_COUNTER: if (idx < 4'h2) evt_true = cnt_zero[idx[0]];
            ptc_pkg::RT_STATE: begin
                if (idx < 4'h3) evt_true = seq_state[idx[1:0]];
                else if (idx == ptc_pkg::IX_CTXID) evt_true = ctxid_match;
                else if (idx == ptc_pkg::IX_VMID) evt_true = vmid_match;
                else if (idx == ptc_pkg::IX_STARTSTOP) evt_true = startstop;
            end
            ptc_pkg::RT_INPUT: begin
                if (idx < 4'h4) evt_true = ext_in[idx[1:0]];
                else if (idx == ptc_pkg::IX_XSEL1) evt_true = xsel_evt[0];
                else if (idx == ptc_pkg::IX_XSEL2) evt_true = xsel_evt[1];
                else if (idx == ptc_pkg::IX_NONSEC) evt_true = nonsecure;
                else if (idx == ptc_pkg::IX_PROHIB) evt_true = prohibited;
                else if (idx == ptc_pkg::IX_ALWAYS) evt_true = 1'b1;
            end
            default: evt_true = 1'b0;
        endcase
    end
endmodule : ptc_event_decode

// ==== core/ptc_trace_ctl.sv ====
// trace program control: apb register slave, hold handshake, packing, events
// assumes pclk domain for generator and resource inputs; ext_in and dlock are pins
`timescale 1ns/100ps
module ptc_trace_ctl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pdbg,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dlock_pin,
    input wire logic [7:0] addr_single,
    input wire logic [3:0] addr_range,
    input wire logic [1:0] cnt_zero,
    input wire logic [2:0] seq_state,
    input wire logic ctxid_match,
    input wire logic vmid_match,
    input wire logic startstop,
    input wire logic [3:0] ext_in_pin,
    input wire logic nonsecure,
    input wire logic prohibited,
    input wire logic [ptc_pkg::PMU_EVT_W-1:0] pmu_events,
    input wire logic tb_valid,
    input wire logic [7:0] tb_data,
    output logic tb_ready,
    output logic atb_valid,
    output logic [31:0] atb_data,
    output logic [1:0] atb_bytes,
    input wire logic atb_ready,
    output logic [31:0] main_ctl,
    output logic [31:0] te_startstop,
    output logic [31:0] te_ctl1,
    output logic [31:0] sync_freq,
    output logic [6:0] trace_id,
    output logic resource_freeze,
    output logic trig_evt,
    output logic te_evt,
    output logic [1:0] ext_out
);
    localparam logic [31:0] PERIPH_ID = 32'h0000_00A5; // arbitrary value

    // pin synchronisers: three stages, change taken when stages 2 and 3 agree
    logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
            pin_f_q <= 5'h00;
        end else begin
            pin_s1_q <= {dlock_pin, ext_in_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int i = 0; i < 5; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) pin_f_q[i] <= pin_s3_q[i];
            end
        end
    end

    logic dlock;
    logic [3:0] ext_in;
    assign dlock = pin_f_q[4];
    assign ext_in = pin_f_q[3:0];

    // apb decode; one wait-free access phase, data captured at setup
    logic setup, wr_en, sw_locked_q;
    logic [11:0] ofs;
    assign setup = psel & ~penable;
    assign ofs = {paddr[11:2], 2'b00};
    assign pready = 1'b1;
    // software writes other than to the lock access register bounce while locked; debugger bypasses the lock
    assign wr_en = psel & penable & pwrite & ~dlock & (pdbg | ~sw_locked_q
        | (ofs == ptc_pkg::OFS_LOCK_ACCESS)) & ~(pdbg & (ofs == ptc_pkg::OFS_LOCK_ACCESS));

    logic [31:0] main_ctl_q, te_ss_q, te_ctl1_q, sync_freq_q, xin_sel_q;
    logic [6:0] trace_id_q;
    logic [ptc_pkg::EVT_W-1:0] evt_q [ptc_pkg::NUM_EVT];
    logic hold, idle, stat_hold_q;
    assign hold = main_ctl_q[ptc_pkg::HOLD_BIT];

    // software lock, set at reset so software must unlock first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sw_locked_q <= 1'b1;
        else if (wr_en && ofs == ptc_pkg::OFS_LOCK_ACCESS)
            sw_locked_q <= (pwdata != ptc_pkg::LOCK_KEY);
    end

    // main control; other config writes only land while held, guarding half setups
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_ctl_q <= ptc_pkg::MAIN_CTL_RST;
        end else if (wr_en && ofs == ptc_pkg::OFS_MAIN_CTL) begin
            main_ctl_q <= pwdata & ptc_pkg::MAIN_CTL_WMASK;
        end
    end

    logic cfg_wr;
    assign cfg_wr = wr_en & hold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_freq_q <= ptc_pkg::SYNC_FREQ_RST;
            trace_id_q <= ptc_pkg::TRACE_ID_RST;
            te_ss_q <= 32'h0000_0000;
            te_ctl1_q <= 32'h0000_0000;
            xin_sel_q <= 32'h0000_0000;
            for (int i = 0; i < ptc_pkg::NUM_EVT; i++) evt_q[i] <= 7'h00;
        end else if (cfg_wr) begin
            case (ofs)
                ptc_pkg::OFS_SYNC_FREQ: sync_freq_q <= pwdata;
                ptc_pkg::OFS_TRACE_ID: trace_id_q <= pwdata[6:0];
                ptc_pkg::OFS_TE_STARTSTOP: te_ss_q <= pwdata;
                ptc_pkg::OFS_TE_CTL1: te_ctl1_q <= pwdata;
                ptc_pkg::OFS_XIN_SEL: xin_sel_q <= pwdata & 32'h0000_7F7F;
                ptc_pkg::OFS_TRIG_EVT: evt_q[0] <= pwdata[6:0];
                ptc_pkg::OFS_TE_EVT: evt_q[1] <= pwdata[6:0];
                ptc_pkg::OFS_EXTOUT_EVT1: evt_q[2] <= pwdata[6:0];
                ptc_pkg::OFS_EXTOUT_EVT2: evt_q[3] <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    // read mux; unmapped reads give zero
    function automatic logic [31:0] rd_mux(input logic [11:0] a, input logic dbg);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ptc_pkg::OFS_MAIN_CTL: r = main_ctl_q;
            ptc_pkg::OFS_STATUS: r[ptc_pkg::STAT_HOLD_BIT] = stat_hold_q;
            ptc_pkg::OFS_TRIG_EVT: r[6:0] = evt_q[0];
            ptc_pkg::OFS_TE_EVT: r[6:0] = evt_q[1];
            ptc_pkg::OFS_EXTOUT_EVT1: r[6:0] = evt_q[2];
            ptc_pkg::OFS_EXTOUT_EVT2: r[6:0] = evt_q[3];
            ptc_pkg::OFS_TE_STARTSTOP: r = te_ss_q;
            ptc_pkg::OFS_TE_CTL1: r = te_ctl1_q;
            ptc_pkg::OFS_SYNC_FREQ: r = sync_freq_q;
            ptc_pkg::OFS_XIN_SEL: r = xin_sel_q;
            ptc_pkg::OFS_TRACE_ID: r[6:0] = trace_id_q;
            ptc_pkg::OFS_LOCK_STATUS: r[1:0] = dbg ? 2'b00 : {sw_locked_q, 1'b1};
            default: if (a >= ptc_pkg::OFS_ID_FIRST) r = PERIPH_ID;
        endcase
        return r;
    endfunction : rd_mux

    // read data and error registered in setup; double lock looks powered off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= dlock ? 32'h0000_0000 : rd_mux(ofs, pdbg);
            pslverr <= dlock;
        end
    end

    // byte packing: emit only on four bytes, or flush remainder when held
    logic [31:0] pack_q;
    logic [2:0] cnt_q;
    logic flush;
    assign flush = hold & (cnt_q != 3'h0);
    assign tb_ready = ~hold & (cnt_q < ptc_pkg::PACK_FULL) & ~atb_valid;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pack_q <= 32'h0000_0000;
            cnt_q <= 3'h0;
        end else if (atb_valid && atb_ready) begin
            cnt_q <= 3'h0;
        end else if (tb_valid && tb_ready) begin
            pack_q[cnt_q[1:0]*8 +: 8] <= tb_data;
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // output beat: data from flops, offered until accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            atb_valid <= 1'b0;
            atb_data <= 32'h0000_0000;
            atb_bytes <= 2'h0;
        end else if (atb_valid) begin
            if (atb_ready) atb_valid <= 1'b0;
        end else if (cnt_q == ptc_pkg::PACK_FULL || flush) begin
            atb_valid <= 1'b1;
            atb_data <= pack_q;
            atb_bytes <= 2'(cnt_q - 3'h1);
        end
    end

    // idle once held with nothing packed and the last beat accepted
    assign idle = hold & (cnt_q == 3'h0) & ~atb_valid;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) stat_hold_q <= 1'b0;
        else stat_hold_q <= idle;
    end

    // selector index past the event bus reads false rather than unknown
    function automatic logic pick_evt(input logic [ptc_pkg::PMU_EVT_W-1:0] ev,
        input logic [ptc_pkg::XIN_SEL_W-1:0] sel);
        logic hit;
        hit = 1'b0;
        if (int'(sel) < ptc_pkg::PMU_EVT_W) hit = ev[sel];
        return hit;
    endfunction : pick_evt

    // selectors stay combinational so they line up with the other resources
    logic [1:0] xsel;
    always_comb begin
        xsel[0] = pick_evt(pmu_events, xin_sel_q[ptc_pkg::XIN_SEL_W-1:0]);
        xsel[1] = pick_evt(pmu_events, xin_sel_q[ptc_pkg::XIN_SEL2_LSB +: ptc_pkg::XIN_SEL_W]);
    end

    // event decoders for trigger, trace enable and both external outputs
    logic [ptc_pkg::NUM_EVT-1:0] evt_hit;
    for (genvar g = 0; g < ptc_pkg::NUM_EVT; g++) begin : g_evt
        ptc_event_decode u_dec (
            .evt_sel(evt_q[g]),
            .addr_single(addr_single),
            .addr_range(addr_range),
            .cnt_zero(cnt_zero),
            .seq_state(seq_state),
            .ctxid_match(ctxid_match),
            .vmid_match(vmid_match),
            .startstop(startstop),
            .ext_in(ext_in),
            .xsel_evt(xsel),
            .nonsecure(nonsecure),
            .prohibited(prohibited),
            .evt_true(evt_hit[g])
        );
    end

    // event outputs registered; all forced low while held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_evt <= 1'b0;
            te_evt <= 1'b0;
            ext_out <= 2'b00;
        end else begin
            trig_evt <= evt_hit[0] & ~hold;
            te_evt <= evt_hit[1] & ~hold;
            ext_out <= evt_hit[3:2] & {2{~hold}};
        end
    end

    assign resource_freeze = hold;
    assign main_ctl = main_ctl_q;
    assign te_startstop = te_ss_q;
    assign te_ctl1 = te_ctl1_q;
    assign sync_freq = sync_freq_q;
    assign trace_id = trace_id_q;

    // checks
    property p_hold_stops_input;
        @(posedge pclk) disable iff (!presetn) hold |-> !tb_ready;
    endproperty
    a_hold_stops_input: assert property (p_hold_stops_input) else $error("input taken in hold");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn) resource_freeze == hold;
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze not following hold");

    property p_extout_low;
        @(posedge pclk) disable iff (!presetn) $past(hold) |-> ext_out == 2'b00;
    endproperty
    a_extout_low: assert property (p_extout_low) else $error("ext out high in hold");

    property p_four_bytes;
        @(posedge pclk) disable iff (!presetn)
            $rose(atb_valid) && !$past(hold) |-> atb_bytes == 2'h3;
    endproperty
    a_four_bytes: assert property (p_four_bytes) else $error("short beat");

    sequence s_drained;
        hold && cnt_q == 3'h0 && !atb_valid;
    endsequence
    property p_status_after_idle;
        @(posedge pclk) disable iff (!presetn) $rose(stat_hold_q) |-> $past(idle);
    endproperty
    a_status_after_idle: assert property (p_status_after_idle) else $error("early status");

    property p_idle_status;
        @(posedge pclk) disable iff (!presetn) s_drained |=> stat_hold_q;
    endproperty
    a_idle_status: assert property (p_idle_status) else $error("status missed idle");

    // hold rising while the sink keeps accepting must reach idle
    sequence s_hold_ready;
        $rose(hold) && atb_ready ##1 atb_ready [*4];
    endsequence
    property p_flush_bounded;
        @(posedge pclk) disable iff (!presetn) s_hold_ready |-> stat_hold_q;
    endproperty
    a_flush_bounded: assert property (p_flush_bounded) else $error("no idle after hold");

    property p_dlock_err;
        @(posedge pclk) disable iff (!presetn)
            setup && dlock |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_dlock_err: assert property (p_dlock_err) else $error("double lock access answered");

    property p_locked_sw;
        @(posedge pclk) disable iff (!presetn)
            sw_locked_q && !pdbg && wr_en |-> ofs == ptc_pkg::OFS_LOCK_ACCESS;
    endproperty
    a_locked_sw: assert property (p_locked_sw) else $error("locked write taken");

    property p_hold_bit;
        @(posedge pclk) disable iff (!presetn)
            wr_en && ofs == ptc_pkg::OFS_MAIN_CTL |=> hold == $past(pwdata[ptc_pkg::HOLD_BIT]);
    endproperty
    a_hold_bit: assert property (p_hold_bit) else $error("hold bit position");

    // a half setup written outside hold must not reach the trigger event register
    property p_cfg_gated;
        @(posedge pclk) disable iff (!presetn)
            !hold && wr_en && ofs == ptc_pkg::OFS_TRIG_EVT |=> $stable(evt_q[0]);
    endproperty
    a_cfg_gated: assert property (p_cfg_gated) else $error("config write without hold");
endmodule : ptc_trace_ctl

// ==== testbench/ptc_atb_sink.sv ====
// trace output sink: accepts beats with an optional stall pattern
// assumes the same clock and reset as the trace control block
`timescale 1ns/100ps
module ptc_atb_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic atb_valid,
    input wire logic [31:0] atb_data,
    input wire logic [1:0] atb_bytes,
    input wire logic stall_en,
    output logic atb_ready,
    output logic got,
    output logic [31:0] got_data,
    output logic [1:0] got_bytes
);
    logic [1:0] cnt_q;
    // stall three cycles of four so pending beats must be held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            atb_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            atb_ready <= !stall_en || (cnt_q == 2'h2);
        end
    end
    // a beat counts only at an edge with valid and ready both high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got <= 1'b0;
            got_data <= 32'h0;
            got_bytes <= 2'h0;
        end else begin
            got <= atb_valid && atb_ready;
            got_data <= atb_data;
            got_bytes <= atb_bytes;
        end
    end
endmodule : ptc_atb_sink

// ==== testbench/ptc_trace_ctl_tb.sv ====
// self-checking bench for the trace control block
// assumes the block and the trace sink partner are compiled first
`timescale 1ns/100ps
module ptc_trace_ctl_tb;
    logic pclk, presetn, psel, penable, pwrite, pdbg, pready, pslverr, dlock_pin;
    logic [31:0] paddr, pwdata, prdata, rdat, main_ctl, atb_data, got_data;
    logic [7:0] addr_single, tb_data;
    logic [3:0] addr_range, ext_in_pin;
    logic [1:0] cnt_zero, atb_bytes, got_bytes, ext_out;
    logic [2:0] seq_state;
    logic ctxid_match, vmid_match, startstop, nonsecure, prohibited, rerr, dbg_mode;
    logic [87:0] pmu_events;
    logic tb_valid, tb_ready, atb_valid, atb_ready, stall_en, got, trig_evt, hold_on;
    logic te_evt, freeze;
    logic [6:0] codes [25];
    logic [7:0] expq [$];
    int seed = 72;
    int mismatches = 0;
    int comparisons = 0;
    logic e;
    ptc_trace_ctl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pdbg(pdbg), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dlock_pin(dlock_pin), .addr_single(addr_single),
        .addr_range(addr_range), .cnt_zero(cnt_zero), .seq_state(seq_state),
        .ctxid_match(ctxid_match), .vmid_match(vmid_match), .startstop(startstop),
        .ext_in_pin(ext_in_pin), .nonsecure(nonsecure), .prohibited(prohibited),
        .pmu_events(pmu_events), .tb_valid(tb_valid), .tb_data(tb_data), .tb_ready(tb_ready),
        .atb_valid(atb_valid), .atb_data(atb_data), .atb_bytes(atb_bytes),
        .atb_ready(atb_ready), .main_ctl(main_ctl), .te_startstop(), .te_ctl1(),
        .sync_freq(), .trace_id(), .resource_freeze(freeze), .trig_evt(trig_evt),
        .te_evt(te_evt),
        .ext_out(ext_out));
    ptc_atb_sink sink_u (.pclk(pclk), .presetn(presetn), .atb_valid(atb_valid),
        .atb_data(atb_data), .atb_bytes(atb_bytes), .stall_en(stall_en),
        .atb_ready(atb_ready), .got(got), .got_data(got_data), .got_bytes(got_bytes));
    // clock at 25 MHz
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        pdbg <= dbg_mode;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // hold handshake: set the hold bit alone, then wait for the status echo
    task automatic set_hold;
        int n;
        hold_on = 1'b1;
        apb(1'b1, 12'h000, 32'h0000_0400);
        n = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0);
            n++;
        end while (rdat[1] !== 1'b1 && n < 60);
        check(n < 60, 1'b1);
        check(expq.size(), 0);
        @(negedge pclk) check(tb_ready, 1'b0);
        check(freeze, 1'b1);
    endtask : set_hold
    task automatic push(input logic [7:0] b);
        @(posedge pclk);
        tb_valid <= 1'b1;
        tb_data <= b;
        expq.push_back(b);
        forever begin
            @(negedge pclk);
            if (tb_ready === 1'b1) break;
        end
        @(posedge pclk);
        tb_valid <= 1'b0;
    endtask : push
    function automatic logic evm(input logic [6:0] c);
        logic [3:0] i;
        i = c[3:0];
        case (c[6:4])
            3'h0: evm = (i < 8) ? addr_single[i[2:0]] : 1'b0;
            3'h1: evm = (i < 4) ? addr_range[i[1:0]] : 1'b0;
            3'h4: evm = (i < 2) ? cnt_zero[i[0]] : 1'b0;
            3'h5: evm = (i < 3) ? seq_state[i[1:0]] : (i == 8) ? ctxid_match :
                (i == 11) ? vmid_match : (i == 15) ? startstop : 1'b0;
            3'h6: evm = (i < 4) ? ext_in_pin[i[1:0]] : (i == 8) ? pmu_events[17] :
                (i == 9) ? pmu_events[86] : (i == 13) ? nonsecure :
                (i == 14) ? prohibited : (i == 15);
            default: evm = 1'b0;
        endcase
    endfunction : evm
    // every accepted beat is compared with the queued bytes
    always @(posedge pclk) begin
        if (got === 1'b1) begin
            check({30'h0, got_bytes}, (!hold_on || expq.size() >= 4) ? 3 : expq.size() - 1);
            for (int k = 0; k <= got_bytes; k++) check(got_data[8*k +: 8], expq.pop_front());
        end
    end
    initial begin
        #(40 * 60000);
        mismatches++;
        final_report();
    end
    initial begin
        codes = '{7'h00, 7'h07, 7'h08, 7'h10, 7'h13, 7'h14, 7'h40, 7'h41, 7'h42, 7'h50,
            7'h52, 7'h58, 7'h5B, 7'h5F, 7'h5C, 7'h60, 7'h63, 7'h68, 7'h69, 7'h6D, 7'h6E,
            7'h6F, 7'h6A, 7'h28, 7'h7F};
        {psel, penable, pwrite, paddr, pwdata, pdbg, dlock_pin, tb_valid, tb_data} = '0;
        {addr_single, addr_range, cnt_zero, seq_state, ctxid_match, vmid_match} = '0;
        {startstop, ext_in_pin, nonsecure, prohibited, pmu_events, stall_en} = '0;
        presetn = 1'b0;
        dbg_mode = 1'b0;
        hold_on = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and the software lock
        apb(1'b0, 12'hFB4, 32'h0); check(rdat, 32'h3);
        apb(1'b1, 12'h000, 32'h0000_0400);
        apb(1'b0, 12'h000, 32'h0); check(rdat, 32'h0);
        apb(1'b1, 12'hFB0, 32'h1234_5678);
        apb(1'b0, 12'hFB4, 32'h0); check(rdat, 32'h1);
        dbg_mode = 1'b1;
        apb(1'b0, 12'hFB4, 32'h0); check(rdat, 32'h0);
        apb(1'b0, 12'h1E0, 32'h0); check(rdat, 32'h400);
        apb(1'b0, 12'hFD0, 32'h0); check(rdat, 32'hA5);
        apb(1'b0, 12'h100, 32'h0); check(rdat, 32'h0);
        apb(1'b1, 12'h008, 32'h6F);
        apb(1'b0, 12'h008, 32'h0); check(rdat, 32'h0);
        $display("reset and lock test done");
        // configure while held; outputs forced low
        set_hold();
        apb(1'b1, 12'h000, 32'hFFFF_FFFF);
        @(negedge pclk) check(main_ctl, 32'h7000_D700);
        apb(1'b1, 12'h1A0, 32'h6F);
        apb(1'b1, 12'h1A4, 32'h08);
        apb(1'b1, 12'h1EC, 32'h0000_5611);
        repeat (3) @(posedge pclk);
        check(ext_out, 2'h0);
        apb(1'b1, 12'h000, 32'h0000_0400);
        apb(1'b1, 12'h000, 32'h0);
        hold_on = 1'b0;
        repeat (3) @(posedge pclk);
        check(ext_out, 2'h1);
        // event decode over the end indices of every listed group and some unlisted codes
        foreach (codes[c]) begin
            set_hold();
            apb(1'b1, 12'h008, {25'h0, codes[c]});
            apb(1'b1, 12'h020, {25'h0, codes[c]});
            ext_in_pin <= 4'($random(seed));
            apb(1'b1, 12'h000, 32'h0);
            hold_on = 1'b0;
            repeat (8) begin
                @(posedge pclk);
                {addr_single, addr_range, cnt_zero, seq_state} <= 17'($random(seed));
                {ctxid_match, vmid_match, startstop, nonsecure, prohibited} <= 5'($random(seed));
                pmu_events <= 88'({$random(seed), $random(seed), $random(seed)});
                @(negedge pclk) e = evm(codes[c]);
                @(negedge pclk) check(trig_evt, e);
                check(te_evt, e);
            end
        end
        $display("event decode test done");
        // packing with a stalling sink, then flush on hold
        stall_en = 1'b1;
        repeat (8) push(8'($random(seed)));
        repeat (2) push(8'($random(seed)));
        repeat (6) @(posedge pclk);
        check(expq.size(), 2);
        set_hold();
        apb(1'b1, 12'h000, 32'h0);
        hold_on = 1'b0;
        $display("trace packing test done");
        // double lock: accesses answer as if powered down
        dlock_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h0000_0400);
        check(rerr, 1'b1);
        apb(1'b0, 12'h1E0, 32'h0); check(rdat, 32'h0);
        dlock_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0); check(rdat, 32'h0);
        $display("double lock test done");
        final_report();
    end
endmodule : ptc_trace_ctl_tb
